// [scm_pkg.sv]
/*
  Constants for the system mode controller: clock rate, timing figures
  with their derived cycle counts, and mode-select codes.
  Assumes a single 250 MHz system clock.
*/
`default_nettype none
package scm_pkg;

  localparam int CLK_MHZ = 250;

  // Mode change must finish within this time (longest, rounds down).
  localparam int T_MOCH_NS = 10000;
  // Bus must stay dominant longer than this (least, rounds up).
  localparam int T_SNM_NS = 4000;
  // Memory check must pass within this time (longest, rounds down).
  localparam int T_START_NS = 8000;
  // Host reset pulse width in reset mode (least, rounds up).
  localparam int T_RST_NS = 8000;

  localparam logic [11:0] MOCH_CYC = 12'((T_MOCH_NS * CLK_MHZ) / 1000);
  localparam logic [11:0] SNM_CYC =
    12'((T_SNM_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] START_CYC = 12'((T_START_NS * CLK_MHZ) / 1000);
  localparam logic [11:0] RST_CYC =
    12'((T_RST_NS * CLK_MHZ + 999) / 1000);

  // Mode-select field codes.
  localparam logic [3:0] MC_NORMAL = 4'hf;
  localparam logic [3:0] MC_STANDBY = 4'h6;
  localparam logic [3:0] MC_SLEEP = 4'h1;
  localparam logic [3:0] MC_LISTEN = 4'h8;

  // Reset value of both synchroniser stages.
  localparam logic [3:0] SYNC_RST = 4'h0;

endpackage : scm_pkg
`default_nettype wire

// [scm_mode_ctrl.sv]
/*
  Main operating-mode state machine of a CAN transceiver with the pin
  controls that each mode implies.
  Assumes SPI decode, memory check, wake filter and interrupt status
  logic run on clk_sys; bus, TXD and battery levels arrive asynchronously.
*/
// Behaviour
// [R1]: Every mode change completes within the mode transition time.
// [R2]: Boot loads configuration; passed memory check in start-up time leaves boot.
// [R3]: Failed memory check enters boot-failure and drives limp output low.
// [R4]: Check mode ends on recessive bus or after check time.
// [R5]: Bus dominant at entry and beyond check time goes straight to normal.
// [R6]: Recessive bus or any valid SPI message since boot skips direct normal.
// [R7]: Direct normal entry after boot sets the direct-normal flag.
// [R8]: Host reset held low in off, boot, check, fail, reset, sleep.
// [R9]: Standby: inhibit high, transmitter off, reset released.
// [R10]: Sleep: inhibit high-impedance, SPI unavailable.
// [R11]: Receive-only passes bus state to RXD, never transmits.
// [R12]: Normal transmits from TXD and reports bus state on RXD.
// [R13]: Mode-select 1111 enters normal mode.
// [R14]: Mode-select 0110 enters standby.
// [R15]: Mode-select 1000 enters receive-only mode.
// [R16]: Mode-select 0001 enters sleep only if enabled and wake source chosen.
// [R17]: A valid wake-up trigger makes the device leave low-power modes.
// [R18]: An SPI system reset forces the machine through a system reset.
// [R19]: Priority transitions win; all others are mutually exclusive.
// [R20]: Pins high-Z before reset mode; pulls and interrupt RXD after.
// [R21]: Interrupt pending when any interrupt status bit is set.
// [R22]: Battery low forces off; battery good restarts boot.
// [R23]: Wake-up from sleep or standby passes through reset mode.
`timescale 1ns/1ps
`default_nettype none
module scm_mode_ctrl (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // Asynchronous levels
  input  wire logic       battery_low,
  input  wire logic       battery_good,
  input  wire logic       can_dominant,
  input  wire logic       txd_pin,
  // Same-clock events and settings
  input  wire logic       boot_done,
  input  wire logic       boot_pass,
  input  wire logic       spi_msg_valid,
  input  wire logic       spi_sys_reset,
  input  wire logic       mode_wr,
  input  wire logic [3:0] mode_select_field,
  input  wire logic       sleep_disable,
  input  wire logic       wake_source_chosen,
  input  wire logic       wake_req,
  input  wire logic       irq_pending,
  input  wire logic       limp_output_control,
  // Mode and status
  output logic      [3:0] mode_q,
  output logic            direct_normal_flag_q,
  output logic            spi_en_q,
  // Transmitter
  output logic            tx_en_q,
  output logic            can_tx_dom_q,
  // Pin controls
  output logic            txd_pull_en_q,
  output logic            spi_select_n_pull_en_q,
  output logic            rxd_o_q,
  output logic            rxd_oe_q,
  output logic            inh_o_q,
  output logic            inh_oe_q,
  output logic            limp_o_q,
  output logic            limp_oe_q,
  output logic            rst_n_o_q,
  output logic            rst_n_oe_q
);

  typedef enum logic [3:0] {
    OFF, BOOT, BOOT_FAILURE_MODE, CHECK, RESET, STANDBY, SLEEP, LISTEN, NORMAL
  } scm_mode_t;

  scm_mode_t   st_q;
  scm_mode_t   st_d;
  logic [11:0] tmr_q;
  logic [11:0] tmr_d;
  logic        dom_q;
  logic        dom_d;
  logic        seen_q;
  logic        seen_d;
  logic        snm_d;
  logic [3:0]  s1_q;
  logic [3:0]  s2_q;
  logic        bat_s;
  logic        good_s;
  logic        can_s;
  logic        txd_s;
  logic        entering;

  // Mode-select decode shared by standby, receive-only and normal.
  function automatic scm_mode_t mc_next(
    input scm_mode_t  cur,
    input logic       wr,
    input logic [3:0] fld,
    input logic       sdis,
    input logic       wsrc
  );
    mc_next = cur;
    if (wr) begin
      if (fld == scm_pkg::MC_NORMAL) begin
        mc_next = NORMAL; // [R13]
      end else if (fld == scm_pkg::MC_STANDBY) begin
        mc_next = STANDBY; // [R14]
      end else if (fld == scm_pkg::MC_LISTEN) begin
        mc_next = LISTEN; // [R15]
      end else if (fld == scm_pkg::MC_SLEEP && !sdis && wsrc) begin
        mc_next = SLEEP; // [R16]
      end
    end
  endfunction : mc_next

  // Two-stage synchronisers; only the second stage is read.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s1_q <= scm_pkg::SYNC_RST;
      s2_q <= scm_pkg::SYNC_RST;
    end else begin
      s1_q <= {txd_pin, can_dominant, battery_good, battery_low};
      s2_q <= s1_q;
    end
  end

  assign bat_s  = s2_q[0];
  assign good_s = s2_q[1];
  assign can_s  = s2_q[2];
  assign txd_s  = s2_q[3];

  // Mode state machine.
  always_comb begin
    st_d = st_q;
    tmr_d = (tmr_q == 12'hfff) ? tmr_q : tmr_q + 12'h0001;
    if (bat_s) begin
      st_d = OFF; // [R22] [R19]
    end else if (spi_sys_reset && st_q != OFF) begin
      st_d = BOOT; // [R18] [R19]
    end else begin
      unique case (st_q)
        OFF: begin
          if (good_s) st_d = BOOT; // [R22]
        end
        BOOT: begin
          if (boot_done) begin
            st_d = boot_pass ? CHECK : BOOT_FAILURE_MODE; // [R2] [R3]
          end else if (tmr_q >= scm_pkg::START_CYC) begin
            st_d = BOOT_FAILURE_MODE; // [R2]
          end
        end
        BOOT_FAILURE_MODE: st_d = BOOT_FAILURE_MODE;
        CHECK: begin
          if (!can_s || seen_q) begin
            st_d = RESET; // [R4] [R6]
          end else if (tmr_q >= scm_pkg::SNM_CYC) begin
            st_d = dom_q ? NORMAL : RESET; // [R4] [R5]
          end
        end
        RESET: begin
          if (tmr_q >= scm_pkg::RST_CYC) st_d = STANDBY;
        end
        STANDBY: begin
          if (wake_req) begin
            st_d = RESET; // [R17] [R23]
          end else begin
            st_d = mc_next(st_q, mode_wr, mode_select_field,
                           sleep_disable, wake_source_chosen);
          end
        end
        SLEEP: begin
          if (wake_req) st_d = RESET; // [R17] [R23]
        end
        LISTEN, NORMAL: begin
          st_d = mc_next(st_q, mode_wr, mode_select_field,
                         sleep_disable, wake_source_chosen);
        end
      endcase
    end
    if (st_d != st_q) tmr_d = 12'h0000;
  end

  assign entering = (st_d != st_q);

  // Boot-time bookkeeping; a set in the clearing cycle wins.
  always_comb begin
    dom_d = dom_q;
    if (entering && st_d == CHECK) dom_d = can_s; // [R5]
    seen_d = ((entering && st_d == BOOT) ? 1'b0 : seen_q)
           | spi_msg_valid; // [R6]
    snm_d = ((entering && st_d == BOOT) ? 1'b0 : direct_normal_flag_q)
          | (st_q == CHECK && st_d == NORMAL); // [R7]
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q                 <= OFF;
      tmr_q                <= 12'h0000;
      dom_q                <= 1'b0;
      seen_q               <= 1'b0;
      direct_normal_flag_q <= 1'b0;
    end else begin
      st_q                 <= st_d;
      tmr_q                <= tmr_d;
      dom_q                <= dom_d;
      seen_q               <= seen_d;
      direct_normal_flag_q <= snm_d;
    end
  end

  // Pin controls follow the next mode so that they switch with it.
  logic pre_rst;
  logic lowp;
  logic act;
  logic [14:0] pin_d;

  always_comb begin
    pre_rst = st_d inside {OFF, BOOT, BOOT_FAILURE_MODE, CHECK};
    lowp    = st_d inside {RESET, SLEEP, STANDBY};
    act     = st_d inside {LISTEN, NORMAL};
    pin_d = '0;
    pin_d[3:0] = st_d;
    pin_d[4] = act || st_d == STANDBY; // [R10]
    pin_d[5] = (st_d == NORMAL); // [R9] [R11] [R12]
    pin_d[6] = (st_d == NORMAL) && !txd_s; // [R12]
    pin_d[7] = !pre_rst; // [R20]
    pin_d[8] = !pre_rst; // [R20]
    // Interrupt pending shows as LOW on RXD in reset and low power.
    pin_d[9] = act ? !can_s : !irq_pending; // [R11] [R20] [R21]
    pin_d[10] = lowp || act; // [R20]
    pin_d[11] = !pre_rst && st_d != SLEEP; // [R9] [R10]
    pin_d[12] = (st_d == BOOT_FAILURE_MODE) || (st_d != OFF && limp_output_control);
    // Reset is released in standby and up; an external pull raises it.
    pin_d[13] = !(st_d inside {STANDBY, LISTEN, NORMAL}); // [R8] [R9]
    pin_d[14] = 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_q         <= 4'h0;
      spi_en_q       <= 1'b0;
      tx_en_q        <= 1'b0;
      can_tx_dom_q   <= 1'b0;
      txd_pull_en_q  <= 1'b0;
      spi_select_n_pull_en_q <= 1'b0;
      rxd_o_q        <= 1'b1;
      rxd_oe_q       <= 1'b0;
      inh_o_q        <= 1'b1;
      inh_oe_q       <= 1'b0;
      limp_o_q       <= 1'b0;
      limp_oe_q      <= 1'b0;
      rst_n_o_q      <= 1'b0;
      rst_n_oe_q     <= 1'b1;
    end else begin
      mode_q         <= pin_d[3:0]; // [R1]
      spi_en_q       <= pin_d[4];
      tx_en_q        <= pin_d[5];
      can_tx_dom_q   <= pin_d[6];
      txd_pull_en_q  <= pin_d[7];
      spi_select_n_pull_en_q <= pin_d[8];
      rxd_o_q        <= pin_d[9];
      rxd_oe_q       <= pin_d[10];
      inh_o_q        <= 1'b1;
      inh_oe_q       <= pin_d[11];
      limp_o_q       <= pin_d[14]; // [R3]
      limp_oe_q      <= pin_d[12]; // [R3]
      rst_n_o_q      <= pin_d[14];
      rst_n_oe_q     <= pin_d[13]; // [R8]
    end
  end

  AST_BAT_OFF: // [R22]
  assert property (@(posedge clk_sys) disable iff (reset)
    bat_s |=> (st_q == OFF) && !inh_oe_q && !spi_en_q)
    else $error("battery low did not force off mode");

  AST_BOOT_FAILURE_MODE_LIMP: // [R3]
  assert property (@(posedge clk_sys) disable iff (reset)
    (st_q == BOOT && boot_done && !boot_pass && !bat_s && !spi_sys_reset)
    |=> (st_q == BOOT_FAILURE_MODE) && limp_oe_q && !limp_o_q)
    else $error("failed memory check did not drive limp low");

  AST_CHECK_ENDS: // [R4]
  assert property (@(posedge clk_sys) disable iff (reset)
    (st_q == CHECK) |-> (tmr_q <= scm_pkg::SNM_CYC))
    else $error("check mode outlived the check time");

  AST_SNM_FLAG: // [R5] [R7]
  assert property (@(posedge clk_sys) disable iff (reset)
    (st_q == CHECK) ##1 (st_q == NORMAL)
    |-> direct_normal_flag_q && $past(dom_q, 2) && tx_en_q)
    else $error("direct normal entry without flag or dominant bus");

  AST_SNM_SPI: // [R6]
  assert property (@(posedge clk_sys) disable iff (reset)
    (st_q == CHECK && (seen_q || !can_s)) |=> (st_q != NORMAL))
    else $error("direct normal taken despite spi message or recessive");

  AST_RST_LOW: // [R8]
  assert property (@(posedge clk_sys) disable iff (reset)
    $past(st_q) inside {OFF, BOOT, BOOT_FAILURE_MODE, CHECK, RESET, SLEEP}
    && st_q == $past(st_q) |-> rst_n_oe_q && !rst_n_o_q)
    else $error("host reset not held low");

  AST_STANDBY_PINS: // [R9]
  assert property (@(posedge clk_sys) disable iff (reset)
    (mode_q == 4'(STANDBY)) |-> inh_oe_q && !tx_en_q && !rst_n_oe_q
    && spi_en_q)
    else $error("standby pin state wrong");

  AST_LISTEN_RX: // [R11]
  assert property (@(posedge clk_sys) disable iff (reset)
    (st_q == LISTEN) ##1 (st_q == LISTEN)
    |-> !tx_en_q && rxd_oe_q && (rxd_o_q == !$past(can_s)))
    else $error("receive-only output wrong");

  AST_MC_NORMAL: // [R1] [R13]
  assert property (@(posedge clk_sys) disable iff (reset)
    (st_q inside {STANDBY, LISTEN} && mode_select_field == scm_pkg::MC_NORMAL
     && mode_wr && !wake_req && !bat_s && !spi_sys_reset)
    |=> (mode_q == 4'(NORMAL)))
    else $error("normal request not completed in transition time");

  AST_SLEEP_REFUSED: // [R16]
  assert property (@(posedge clk_sys) disable iff (reset)
    (st_q != SLEEP && mode_select_field == scm_pkg::MC_SLEEP && mode_wr
     && (sleep_disable || !wake_source_chosen)) |=> (st_q != SLEEP))
    else $error("sleep accepted while disabled");

  AST_WAKE_RESET: // [R23]
  assert property (@(posedge clk_sys) disable iff (reset)
    (st_q == SLEEP && wake_req && !bat_s && !spi_sys_reset)
    |=> (st_q == RESET) ##1 !spi_en_q)
    else $error("wake-up from sleep skipped reset mode");

endmodule : scm_mode_ctrl
`default_nettype wire

// [scm_host_model.sv]
/*
  Host microcontroller model: sends mode-select writes and SPI system
  reset commands as the SPI decoder would present them to the device.
  Assumes the caller starts each frame from a clk_sys context.
*/
`timescale 1ns/1ps
`default_nettype none
module scm_host_model (
  // Clock
  input  wire logic       clk_sys,
  // Decoded SPI frame
  output var  logic       mode_wr,
  output var  logic [3:0] mode_select_field,
  output var  logic       spi_msg_valid,
  output var  logic       spi_sys_reset
);
  initial begin
    mode_wr = 1'b0;
    mode_select_field = 4'h0;
    spi_msg_valid = 1'b0;
    spi_sys_reset = 1'b0;
  end

  // A reset frame carries no message flag, so the direct-normal path
  // after the reboot stays open.
  task automatic send(input logic [3:0] code, input logic sys_rst);
    @(posedge clk_sys);
    mode_wr <= ~sys_rst;
    mode_select_field <= code;
    spi_msg_valid <= ~sys_rst;
    spi_sys_reset <= sys_rst;
    @(posedge clk_sys);
    mode_wr <= 1'b0;
    spi_msg_valid <= 1'b0;
    spi_sys_reset <= 1'b0;
    // The released field shows the inverse so a stale value is not reused.
    mode_select_field <= ~code;
  endtask : send
endmodule : scm_host_model
`default_nettype wire

// [scm_mode_ctrl_tb_top.sv]
/*
  Self-checking testbench for the system mode controller.
  Assumes the host model drives the SPI-side strobes; levels come from here.
*/
`timescale 1ns/1ps
`default_nettype none
module scm_mode_ctrl_tb_top;
  logic clk_sys, reset, battery_low, battery_good, can_dominant, txd_pin;
  logic boot_done, boot_pass, sleep_disable, wake_source_chosen, wake_req;
  logic irq_pending, limp_output_control;
  wire logic       mode_wr, spi_msg_valid, spi_sys_reset;
  wire logic [3:0] mode_select_field, mode_q;
  wire logic       direct_normal_flag_q, spi_en_q, tx_en_q, can_tx_dom_q;
  wire logic       txd_pull_en_q, spi_select_n_pull_en_q, rxd_o_q, rxd_oe_q;
  wire logic       inh_o_q, inh_oe_q, limp_o_q, limp_oe_q;
  wire logic       rst_n_o_q, rst_n_oe_q;
  int              fails, compares;

  scm_host_model host (.clk_sys, .mode_wr, .mode_select_field,
    .spi_msg_valid, .spi_sys_reset);
  scm_mode_ctrl dut (.clk_sys, .reset, .battery_low, .battery_good,
    .can_dominant, .txd_pin, .boot_done, .boot_pass, .spi_msg_valid,
    .spi_sys_reset, .mode_wr, .mode_select_field, .sleep_disable,
    .wake_source_chosen, .wake_req, .irq_pending, .limp_output_control,
    .mode_q, .direct_normal_flag_q, .spi_en_q, .tx_en_q, .can_tx_dom_q,
    .txd_pull_en_q, .spi_select_n_pull_en_q, .rxd_o_q, .rxd_oe_q, .inh_o_q,
    .inh_oe_q, .limp_o_q, .limp_oe_q, .rst_n_o_q, .rst_n_oe_q);

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic wait_mode(input logic [3:0] m, input int bound);
    int i;
    for (i = 0; i < bound && mode_q !== m; i++) tick(1);
    check(mode_q === m, "mode not reached in time");
    if (mode_q !== m) conclude();
  endtask : wait_mode

  task automatic boot(input logic pass);
    @(posedge clk_sys);
    boot_pass <= pass;
    boot_done <= 1'b1;
    @(posedge clk_sys);
    boot_done <= 1'b0;
  endtask : boot

  task automatic boot_direct();
    @(posedge clk_sys);
    battery_good <= 1'b1;
    wait_mode(4'h1, 6);
    check(rst_n_oe_q === 1'b1 && inh_oe_q === 1'b0, "boot pins");
    boot(1'b1);
    wait_mode(4'h3, 2);
    tick(900);
    check(mode_q === 4'h3, "check ended early");
    wait_mode(4'h8, 200);
    check(direct_normal_flag_q === 1'b1, "direct flag");
    @(posedge clk_sys);
    txd_pin <= 1'b0;
    tick(5);
    check(can_tx_dom_q === 1'b1 && rxd_o_q === 1'b0, "tx path");
  endtask : boot_direct

  task automatic modes();
    host.send(scm_pkg::MC_STANDBY, 1'b0);
    wait_mode(4'h5, 2);
    check(inh_oe_q === 1'b1 && inh_o_q === 1'b1 && tx_en_q === 1'b0
      && rst_n_oe_q === 1'b0, "standby pins");
    check(txd_pull_en_q === 1'b1 && spi_select_n_pull_en_q === 1'b1, "pulls");
    @(posedge clk_sys);
    irq_pending <= 1'b1;
    tick(2);
    check(rxd_o_q === 1'b0 && rxd_oe_q === 1'b1, "irq on rxd");
    @(posedge clk_sys);
    irq_pending <= 1'b0;
    host.send(scm_pkg::MC_LISTEN, 1'b0);
    wait_mode(4'h7, 2);
    tick(3);
    check(can_tx_dom_q === 1'b0 && rxd_o_q === 1'b0, "listen");
    host.send(scm_pkg::MC_NORMAL, 1'b0);
    wait_mode(4'h8, 2);
    @(posedge clk_sys);
    sleep_disable <= 1'b1;
    host.send(scm_pkg::MC_SLEEP, 1'b0);
    tick(2);
    check(mode_q === 4'h8, "sleep not refused");
    @(posedge clk_sys);
    sleep_disable <= 1'b0;
    host.send(scm_pkg::MC_SLEEP, 1'b0);
    wait_mode(4'h6, 2);
    check(inh_oe_q === 1'b0 && spi_en_q === 1'b0 && rst_n_oe_q === 1'b1,
      "sleep pins");
    @(posedge clk_sys);
    wake_req <= 1'b1;
    @(posedge clk_sys);
    wake_req <= 1'b0;
    wait_mode(4'h4, 3);
    check(rst_n_oe_q === 1'b1 && rst_n_o_q === 1'b0 && spi_en_q === 1'b0,
      "reset mode");
    wait_mode(4'h5, int'(scm_pkg::RST_CYC) + 5);
  endtask : modes

  task automatic boot_faults();
    @(posedge clk_sys);
    txd_pin <= 1'b1;
    host.send(4'h0, 1'b1);
    wait_mode(4'h1, 3);
    check(direct_normal_flag_q === 1'b0, "flag not cleared");
    boot(1'b0);
    wait_mode(4'h2, 2);
    check(limp_oe_q === 1'b1 && limp_o_q === 1'b0, "limp low");
    @(posedge clk_sys);
    can_dominant <= 1'b0;
    host.send(4'h0, 1'b1);
    wait_mode(4'h1, 3);
    boot(1'b1);
    // A recessive bus ends the check after a single cycle.
    tick(0);
    check(mode_q === 4'h3, "check not entered");
    wait_mode(4'h4, 4);
    check(direct_normal_flag_q === 1'b0, "recessive went direct");
  endtask : boot_faults

  task automatic battery_drop();
    @(posedge clk_sys);
    battery_low <= 1'b1;
    wait_mode(4'h0, 6);
    host.send(4'h0, 1'b1);
    tick(2);
    check(mode_q === 4'h0 && rst_n_oe_q === 1'b1, "off held");
    @(posedge clk_sys);
    battery_low <= 1'b0;
    wait_mode(4'h1, 6);
    // A message during boot must block the direct path on a dominant bus.
    @(posedge clk_sys);
    can_dominant <= 1'b1;
    host.send(scm_pkg::MC_NORMAL, 1'b0);
    boot(1'b1);
    tick(0);
    check(mode_q === 4'h3, "check not entered");
    wait_mode(4'h4, 4);
    check(direct_normal_flag_q === 1'b0, "spi message went direct");
  endtask : battery_drop

  initial begin
    fails = 0;
    compares = 0;
    reset = 1'b1;
    battery_low = 1'b0;
    battery_good = 1'b0;
    can_dominant = 1'b1;
    txd_pin = 1'b1;
    boot_done = 1'b0;
    boot_pass = 1'b0;
    sleep_disable = 1'b0;
    wake_source_chosen = 1'b1;
    wake_req = 1'b0;
    irq_pending = 1'b0;
    limp_output_control = 1'b0;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    tick(3);
    check(mode_q === 4'h0 && rxd_oe_q === 1'b0, "off state");
    boot_direct();
    modes();
    boot_faults();
    battery_drop();
    conclude();
  end
endmodule : scm_mode_ctrl_tb_top
`default_nettype wire
